// file: rtl/swm_ctrl.sv
// Operating mode, wake-up and supply source controller
//
// What this block does
// - Temperature change wakes from sleep unless temperature measurement is disabled.
// - Supply voltage change sets its flag and wakes only when enabled.
// - Main supply restoring wakes unless metering power-down is set, and sets rail source bit 6.
// - RTC interval expiry, which has no enable, sets its flag, raises RTC irq, wakes.
// - RTC alarm wakes only when its alarm enable bits are set.
// - INT0 edge wakes when config is 1; polarity from edge bit; flag untouched.
// - INT1 edge wakes when config is 11x; polarity from edge bit; flag untouched.
// - UART2 receive edge wakes when config is 11 and sets bit 7.
// - External reset low during sleep wakes into battery mode.
// - The four scratch registers keep their values through sleep.
// - In sleep all pins are inputs; pull-ups disabled per pin.
// - Enabled switchover moves rail to battery and disables metering analog.
// - On battery, setting power control bit 4 enters sleep, core off.
// - Wake from sleep into battery mode restarts core at reset vector.
// - Supply restore in sleep enters normal mode, restarts core and analog.
// - Supply return in battery mode restarts analog; core keeps running.
// - Switchover on low supply input happens 30 ms after enabling.
// - Return to main supply only above 2.75 V with power-down cleared.
`timescale 1ns/100ps
`include "swm_regs.svh"
module swm_ctrl #(
    parameter int unsigned SWITCH_DELAY_CYC = `SWM_SWITCH_DELAY_MS * `SWM_CLK_KHZ
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire swm_pkg::swm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output swm_pkg::swm_byte_t reg_rdata,
    input wire logic temp_change,
    input wire logic supply_adc_change,
    input wire logic rtc_interval_expired,
    input wire logic rtc_alarm,
    input wire logic ext_int0_n,
    input wire logic ext_int1_n,
    input wire logic uart2_receive_line,
    input wire logic ext_reset_n,
    input wire logic vdd_low,
    input wire logic supply_sense_low,
    input wire logic vdd_above_2v75,
    output logic [1:0] op_mode,
    output logic switched_rail,
    output logic core_power_on,
    output logic core_restart,
    output logic metering_analog_on,
    output logic power_mgmt_irq,
    output logic rtc_irq,
    output logic pins_force_input,
    output logic [23:0] pullup_enable
);
    import swm_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NSYNC = 3;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_r;
    logic [NSYNC-1:0] s2_r;
    logic [NSYNC-1:0] s3_r;
    logic [NSYNC-1:0] pin_r;
    assign pin_raw = {uart2_receive_line, ext_int1_n, ext_int0_n};

    // Three stages; a level counts only once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_r <= {NSYNC{1'b1}};
            s2_r <= {NSYNC{1'b1}};
            s3_r <= {NSYNC{1'b1}};
            pin_r <= {NSYNC{1'b1}};
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
        end
    end

    logic rst_s1_r;
    logic rst_s2_r;
    logic rst_s3_r;
    logic rst_pin_r;
    // Reset pin through the same filter; idle high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
            rst_s3_r <= 1'b1;
            rst_pin_r <= 1'b1;
        end else begin
            rst_s1_r <= ext_reset_n;
            rst_s2_r <= rst_s1_r;
            rst_s3_r <= rst_s2_r;
            rst_pin_r <= (rst_s2_r & rst_s3_r) | (rst_pin_r & (rst_s2_r | rst_s3_r));
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    swm_byte_t timer_control_r;
    swm_byte_t rtc_config_two_r;
    swm_byte_t pull0_r;
    swm_byte_t pull1_r;
    swm_byte_t pull2_r;
    swm_byte_t power_control_r;
    swm_byte_t power_irq_enable_r;
    swm_byte_t temp_supply_delta_r;
    swm_byte_t wake_config_r;
    swm_byte_t switch_ctrl_r;
    swm_byte_t scratch_r [4];
    logic rail_source_flag_r;
    logic uart2_rx_edge_flag_r;
    logic [4:0] wake_flags_r;
    logic [NSYNC-1:0] pin_d_r;
    swm_mode_e mode_r;
    swm_mode_e mode_nxt;

    wire wr_timer_control = reg_wr && reg_addr == `SWM_OFS_TIMER_CONTROL;
    wire wr_per = reg_wr && reg_addr == `SWM_OFS_PERIPHERAL_CONFIG;
    wire wr_flags = reg_wr && reg_addr == `SWM_OFS_WAKE_FLAGS;
    wire wr_pow = reg_wr && reg_addr == `SWM_OFS_POWER_CONTROL;
    // Scratch pad spans four consecutive offsets starting at the first one
    wire scratch_hit = reg_addr >= `SWM_OFS_SCRATCH0 && reg_addr <= `SWM_OFS_SCRATCH0 + 8'h03;
    wire [1:0] scratch_idx = 2'(reg_addr - `SWM_OFS_SCRATCH0);
    wire in_sleep = mode_r == SWM_SLEEP;

    // Edge detection on the filtered pins
    wire [2:0] pin_rise = pin_r & ~pin_d_r;
    wire [2:0] pin_fall = ~pin_r & pin_d_r;
    wire int0_edge = timer_control_r[`SWM_BIT_IT0] ? pin_fall[0] : pin_rise[0];
    wire int1_edge = timer_control_r[`SWM_BIT_IT1] ? pin_fall[1] : pin_rise[1];
    wire rx_edge = pin_rise[2] | pin_fall[2];

    // Wake sources, each with its own gate except the RTC interval expiry and the reset pin
    wire ev_temp = temp_change && (temp_supply_delta_r & `SWM_TEMP_MEAS_MASK) != 8'h00;
    wire ev_vadc = supply_adc_change && power_irq_enable_r[`SWM_BIT_SUPPLY_ADC_EN];
    wire ev_rtc_int = rtc_interval_expired;
    wire ev_alarm = rtc_alarm && (rtc_config_two_r & `SWM_ALARM_EN_MASK) != 8'h00;
    wire ev_int0 = int0_edge && wake_config_r[1:0] == 2'b01;
    wire ev_int1 = int1_edge && wake_config_r[4:3] == 2'b11;
    wire ev_rx = rx_edge && wake_config_r[6:5] == 2'b11;
    wire ev_rst = in_sleep && !rst_pin_r;

    // Supply decisions
    wire restore_ok = vdd_above_2v75 && !switch_ctrl_r[`SWM_BIT_METER_METERING_POWER_DOWN];
    logic [31:0] dcin_cnt_r;
    wire dcin_due = dcin_cnt_r == SWITCH_DELAY_CYC;
    wire switchover = mode_r == SWM_NORMAL &&
        ((vdd_low && switch_ctrl_r[`SWM_BIT_VDD_SWITCH_EN]) || dcin_due);
    wire restore = mode_r != SWM_NORMAL && restore_ok;
    wire maskable_wake = ev_temp | ev_vadc | ev_rtc_int | ev_alarm | ev_int0 | ev_int1 | ev_rx;

    // Mode transitions
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            SWM_NORMAL: if (switchover) mode_nxt = SWM_BATTERY;
            SWM_BATTERY: begin
                if (restore) begin
                    mode_nxt = SWM_NORMAL;
                end else if (wr_pow && reg_wdata[`SWM_BIT_SLEEP]) begin
                    mode_nxt = SWM_SLEEP;
                end
            end
            SWM_SLEEP: begin
                if (restore) begin
                    mode_nxt = SWM_NORMAL;
                end else if (maskable_wake || ev_rst) begin
                    mode_nxt = SWM_BATTERY;
                end
            end
            default: mode_nxt = SWM_NORMAL;
        endcase
    end

    // Low supply-input switchover delay: counts once armed with the input low
    always_ff @(posedge clk_sys) begin
        if (reset || !(supply_sense_low && switch_ctrl_r[`SWM_BIT_DCIN_SWITCH_EN])
            || mode_r != SWM_NORMAL) begin
            dcin_cnt_r <= 32'h0;
        end else if (!dcin_due) begin
            dcin_cnt_r <= dcin_cnt_r + 32'h1;
        end
    end

    // Mode and outputs; core restart pulses on every exit from sleep
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mode_r <= SWM_NORMAL;
            core_restart <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            core_restart <= in_sleep && mode_nxt != SWM_SLEEP;
        end
    end

    // Sticky wake flags: set wins over a software clear; held across sleep
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wake_flags_r <= 5'h0;
            uart2_rx_edge_flag_r <= 1'b0;
            rail_source_flag_r <= 1'b1;
            pin_d_r <= {NSYNC{1'b1}};
        end else begin
            pin_d_r <= pin_r;
            wake_flags_r <= (wake_flags_r & ~(wr_flags ? reg_wdata[4:0] : 5'h0))
                | {ev_rst, ev_alarm, ev_rtc_int, ev_vadc, ev_temp};
            uart2_rx_edge_flag_r <= ev_rx
                || (uart2_rx_edge_flag_r && !(wr_per && !reg_wdata[`SWM_BIT_RX2_FLAG]));
            rail_source_flag_r <= mode_nxt == SWM_NORMAL;
        end
    end

    // Software registers; retained in every mode since this logic is always powered
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            timer_control_r <= `SWM_RST_BYTE;
            rtc_config_two_r <= `SWM_RST_BYTE;
            pull0_r <= `SWM_RST_PULLUP;
            pull1_r <= `SWM_RST_PULLUP;
            pull2_r <= `SWM_RST_PULLUP;
            power_control_r <= `SWM_RST_BYTE;
            power_irq_enable_r <= `SWM_RST_BYTE;
            temp_supply_delta_r <= `SWM_RST_BYTE;
            wake_config_r <= `SWM_RST_BYTE;
            switch_ctrl_r <= `SWM_RST_BYTE;
            for (int i = 0; i < 4; i++) begin
                scratch_r[i] <= `SWM_RST_BYTE;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `SWM_OFS_TIMER_CONTROL: timer_control_r <= reg_wdata;
                `SWM_OFS_RTC_CONFIG_TWO: rtc_config_two_r <= reg_wdata;
                `SWM_OFS_PORT0_PULLUP: pull0_r <= reg_wdata;
                `SWM_OFS_PORT1_PULLUP: pull1_r <= reg_wdata;
                `SWM_OFS_PORT2_PULLUP: pull2_r <= reg_wdata;
                `SWM_OFS_POWER_CONTROL: power_control_r <= reg_wdata & 8'hef;
                `SWM_OFS_POWER_IRQ_ENABLE: power_irq_enable_r <= reg_wdata;
                `SWM_OFS_TEMP_SUPPLY_DELTA: temp_supply_delta_r <= reg_wdata;
                `SWM_OFS_WAKE_CONFIG: wake_config_r <= reg_wdata;
                `SWM_OFS_SWITCH_CTRL: switch_ctrl_r <= reg_wdata;
                default: begin
                    if (scratch_hit) begin
                        scratch_r[scratch_idx] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Read path and outputs
    // ************************************************************
    swm_byte_t rd_mux;
    // Flag bits of timer control are never touched here, the wake edge leaves them alone
    always_comb begin
        case (reg_addr)
            `SWM_OFS_TIMER_CONTROL: rd_mux = timer_control_r;
            `SWM_OFS_RTC_CONFIG_TWO: rd_mux = rtc_config_two_r;
            `SWM_OFS_PORT0_PULLUP: rd_mux = pull0_r;
            `SWM_OFS_PORT1_PULLUP: rd_mux = pull1_r;
            `SWM_OFS_PORT2_PULLUP: rd_mux = pull2_r;
            `SWM_OFS_POWER_CONTROL: rd_mux = power_control_r;
            `SWM_OFS_POWER_IRQ_ENABLE: rd_mux = power_irq_enable_r;
            `SWM_OFS_TEMP_SUPPLY_DELTA: rd_mux = temp_supply_delta_r;
            `SWM_OFS_WAKE_CONFIG: rd_mux = wake_config_r;
            `SWM_OFS_SWITCH_CTRL: rd_mux = switch_ctrl_r;
            `SWM_OFS_WAKE_FLAGS: rd_mux = {3'b000, wake_flags_r};
            `SWM_OFS_PERIPHERAL_CONFIG: rd_mux = {uart2_rx_edge_flag_r, rail_source_flag_r,
                4'h0, mode_r};
            default: rd_mux = scratch_hit ? scratch_r[scratch_idx] : 8'h00;
        endcase
    end

    // Registered outputs; the metering analog only runs on the main supply
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 8'h00;
            op_mode <= 2'b00;
            switched_rail <= 1'b0;
            core_power_on <= 1'b1;
            metering_analog_on <= 1'b1;
            power_mgmt_irq <= 1'b0;
            rtc_irq <= 1'b0;
            pins_force_input <= 1'b0;
            pullup_enable <= 24'hffffff;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            op_mode <= mode_nxt;
            switched_rail <= mode_nxt != SWM_NORMAL;
            core_power_on <= mode_nxt != SWM_SLEEP;
            metering_analog_on <= mode_nxt == SWM_NORMAL;
            power_mgmt_irq <= wake_flags_r[1] ||
                (power_irq_enable_r[`SWM_BIT_SWITCHOVER_EN] && switchover) ||
                (power_irq_enable_r[`SWM_BIT_RESTORED_EN] && restore);
            rtc_irq <= wake_flags_r[2] || wake_flags_r[3];
            pins_force_input <= mode_nxt == SWM_SLEEP;
            pullup_enable <= {pull2_r, pull1_r, pull0_r};
        end
    end
endmodule // swm_ctrl

// file: inc/swm_regs.svh
// Register offsets, field positions, reset values and timing counts of the mode controller
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
`define SWM_OFS_TIMER_CONTROL 8'h88
`define SWM_OFS_RTC_CONFIG_TWO 8'ha2
`define SWM_OFS_PORT0_PULLUP 8'hb2
`define SWM_OFS_PORT1_PULLUP 8'hb3
`define SWM_OFS_PORT2_PULLUP 8'hb4
`define SWM_OFS_POWER_CONTROL 8'hc5
`define SWM_OFS_POWER_IRQ_ENABLE 8'hec
`define SWM_OFS_TEMP_SUPPLY_DELTA 8'hf3
`define SWM_OFS_PERIPHERAL_CONFIG 8'hf4
`define SWM_OFS_SCRATCH0 8'hfb
`define SWM_OFS_WAKE_CONFIG 8'hff
`define SWM_OFS_WAKE_FLAGS 8'hf0
`define SWM_OFS_SWITCH_CTRL 8'hf1
`define SWM_BIT_SLEEP 4
`define SWM_BIT_RAIL_SOURCE 6
`define SWM_BIT_RX2_FLAG 7
`define SWM_BIT_IT0 0
`define SWM_BIT_IE0 1
`define SWM_BIT_IT1 2
`define SWM_BIT_IE1 3
`define SWM_BIT_SUPPLY_ADC_EN 1
`define SWM_BIT_SWITCHOVER_EN 2
`define SWM_BIT_RESTORED_EN 3
`define SWM_BIT_DCIN_SWITCH_EN 1
`define SWM_BIT_VDD_SWITCH_EN 0
`define SWM_BIT_METER_METERING_POWER_DOWN 2
`define SWM_RST_BYTE 8'h00
`define SWM_RST_PULLUP 8'hff
`define SWM_TEMP_MEAS_MASK 8'h03
`define SWM_ALARM_EN_MASK 8'h03
`define SWM_SWITCH_DELAY_MS 30
`define SWM_CLK_KHZ 125000
`endif

// file: inc/swm_pkg.sv
// Types shared by the sleep and wake-up mode controller
package swm_pkg;
    typedef enum logic [1:0] {
        SWM_NORMAL,
        SWM_BATTERY,
        SWM_SLEEP
    } swm_mode_e;
    typedef logic [7:0] swm_byte_t;
endpackage

// file: sim/swm_ctrl_monitor.sv
// Port-level assertion checker for the sleep and wake-up mode controller
`timescale 1ns/100ps
module swm_ctrl_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire swm_pkg::swm_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic ext_reset_n,
    input wire logic rtc_interval_expired,
    input wire logic vdd_above_2v75,
    input wire logic [1:0] op_mode,
    input wire logic switched_rail,
    input wire logic core_power_on,
    input wire logic core_restart,
    input wire logic metering_analog_on,
    input wire logic pins_force_input,
    input wire logic rtc_irq
);
    import swm_pkg::*;
    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Sleep request while on battery
    sequence s_sleep_cmd;
        reg_wr && reg_addr == 8'hc5 && reg_wdata[4] && op_mode == 2'h1;
    endsequence
    // Reset pin held low during sleep
    sequence s_rst_hold;
        op_mode == 2'h2 && !ext_reset_n;
    endsequence
    property p_sleep_entry; s_sleep_cmd |=> op_mode == 2'h2; endproperty
    property p_sleep_state;
        op_mode == 2'h2 |-> !core_power_on && pins_force_input && switched_rail;
    endproperty
    // Filter latency is a few cycles, so allow up to eight
    property p_reset_wake; s_rst_hold |-> ##[1:8] op_mode == 2'h1; endproperty
    property p_restart_src; core_restart |-> $past(op_mode) == 2'h2 && core_power_on; endproperty
    property p_restart_pulse; core_restart |=> !core_restart; endproperty
    property p_batt_state;
        op_mode != 2'h0 |-> switched_rail && !metering_analog_on;
    endproperty
    property p_rtc_irq; rtc_interval_expired |-> ##[1:2] rtc_irq; endproperty
    property p_rail_main;
        $fell(switched_rail) |-> $past(vdd_above_2v75) && op_mode == 2'h0;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
    a_sleep_state: assert property (p_sleep_state) else $error("sleep outputs wrong");
    a_reset_wake: assert property (p_reset_wake) else $error("reset pin did not wake");
    a_restart_src: assert property (p_restart_src) else $error("restart not from sleep");
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
    a_batt_state: assert property (p_batt_state) else $error("battery outputs wrong");
    a_rtc_irq: assert property (p_rtc_irq) else $error("interval irq missing");
    a_rail_main: assert property (p_rail_main) else $error("rail returned early");
endmodule // swm_ctrl_checker
bind swm_ctrl swm_ctrl_checker swm_ctrl_checker_inst (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ext_reset_n(ext_reset_n),
    .rtc_interval_expired(rtc_interval_expired), .vdd_above_2v75(vdd_above_2v75),
    .op_mode(op_mode), .switched_rail(switched_rail), .core_power_on(core_power_on),
    .core_restart(core_restart), .metering_analog_on(metering_analog_on),
    .pins_force_input(pins_force_input), .rtc_irq(rtc_irq));

// file: sim/swm_supply_model.sv
// Behavioural model of the supply comparators feeding the controller
`timescale 1ns/100ps
module swm_supply_model (
    input wire logic clk_sys,
    input wire logic mains_ok,
    input wire logic sense_ok,
    output logic vdd_low,
    output logic supply_sense_low,
    output logic vdd_above_2v75
);
    // Comparators settle one clock after the supply moves
    always_ff @(posedge clk_sys) begin
        vdd_low <= !mains_ok;
        vdd_above_2v75 <= mains_ok;
        supply_sense_low <= !sense_ok;
    end
endmodule // swm_supply_model

// file: sim/swm_ctrl_tb.sv
// Self-checking testbench for the sleep and wake-up mode controller
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module swm_ctrl_tb;
    import swm_pkg::*;
    localparam logic [7:0] EN_A [8] = '{8'hf3, 8'hec, 8'hf3, 8'ha2, 8'hff, 8'hff, 8'hff, 8'hf3};
    localparam logic [7:0] EN_D [8] = '{8'h01, 8'h06, 8'h01, 8'h01, 8'h01, 8'h18, 8'h60, 8'h01};
    localparam logic [7:0] FL_A [8] = '{8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'h88, 8'h88, 8'hf4, 8'hf0};
    localparam logic [7:0] FL_D [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h05, 8'h05, 8'h81, 8'h10};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    swm_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    swm_byte_t reg_rdata;
    logic [3:0] ev = 4'h0;
    logic [3:0] pin_n = 4'hf;
    logic mains_ok = 1'b1;
    logic sense_ok = 1'b1;
    logic vdd_low, supply_sense_low, vdd_above_2v75;
    logic [1:0] op_mode;
    logic switched_rail, core_power_on, core_restart, metering_analog_on;
    logic power_mgmt_irq, rtc_irq, pins_force_input;
    logic [23:0] pullup_enable;
    int bad_count = 0;
    int cmp_count = 0;
    int rs_cnt = 0;
    // Short switchover delay keeps the run brief
    swm_ctrl #(.SWITCH_DELAY_CYC(20)) swm_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .temp_change(ev[0]), .supply_adc_change(ev[1]),
        .rtc_interval_expired(ev[2]), .rtc_alarm(ev[3]), .ext_int0_n(pin_n[0]),
        .ext_int1_n(pin_n[1]), .uart2_receive_line(pin_n[2]), .ext_reset_n(pin_n[3]),
        .vdd_low(vdd_low), .supply_sense_low(supply_sense_low),
        .vdd_above_2v75(vdd_above_2v75), .op_mode(op_mode), .switched_rail(switched_rail),
        .core_power_on(core_power_on), .core_restart(core_restart),
        .metering_analog_on(metering_analog_on), .power_mgmt_irq(power_mgmt_irq),
        .rtc_irq(rtc_irq), .pins_force_input(pins_force_input), .pullup_enable(pullup_enable));
    swm_supply_model swm_supply_model_inst (.clk_sys(clk_sys), .mains_ok(mains_ok),
        .sense_ok(sense_ok), .vdd_low(vdd_low), .supply_sense_low(supply_sense_low),
        .vdd_above_2v75(vdd_above_2v75));
    // ****************
    // Bus and helper tasks
    // ****************
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Count restart pulses so each scenario can tell a reset vector start
    always @(posedge clk_sys) begin
        if (core_restart === 1'b1) rs_cnt++;
    end
    task automatic wr(input logic [7:0] a, input swm_byte_t d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input swm_byte_t e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int i;
        i = 0;
        while (i < 40 && op_mode !== m) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        `CHK(op_mode, m)
    endtask
    // Flags are cleared first so each scenario's flag read sees only its own event
    task automatic go_sleep;
        wr(8'hf0, 8'hff);
        wr(8'hf4, 8'h00);
        wr(8'hc5, 8'h10);
        #1;
        `CHK({op_mode, core_power_on, pins_force_input}, 4'h9)
        rs_cnt = 0;
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset;
        `CHK(pullup_enable, 24'hffffff)
        rd(8'hb4, 8'hff);
        wr(8'hb3, 8'h5a);
        rd(8'hb3, 8'h5a);
        `CHK(pullup_enable[15:8], 8'h5a)
        wr(8'h10, 8'h33);
        rd(8'h10, 8'h00);
        rd(8'hf4, 8'h40);
        for (int i = 0; i < 4; i++) wr(8'hfb + 8'(i), 8'h11 * 8'(i + 1));
        wr(8'h88, 8'h05);
        wr(8'hec, 8'h04);
        wr(8'hf1, 8'h01);
        wr(8'hc5, 8'h10);
        #1;
        `CHK(op_mode, 2'h0)
    endtask
    task automatic t_battery;
        @(posedge clk_sys);
        mains_ok <= 1'b0;
        wait_mode(2'h1);
        `CHK({switched_rail, metering_analog_on}, 2'b10)
        rd(8'hf4, 8'h01);
    endtask
    task automatic t_wake(input int k);
        wr(EN_A[k], EN_D[k]);
        go_sleep();
        @(posedge clk_sys);
        if (k < 4) ev[k] <= 1'b1;
        else pin_n[k - 4] <= 1'b0;
        @(posedge clk_sys);
        ev <= 4'h0;
        wait_mode(2'h1);
        @(posedge clk_sys);
        pin_n <= 4'hf;
        #1;
        `CHK(rs_cnt, 1)
        rd(FL_A[k], FL_D[k]);
        if (k == 1) `CHK(power_mgmt_irq, 1'b1)
        if (k == 2) `CHK(rtc_irq, 1'b1)
    endtask
    task automatic t_mask;
        wr(8'hf3, 8'h00);
        wr(8'hff, 8'h00);
        go_sleep();
        @(posedge clk_sys);
        ev[0] <= 1'b1;
        pin_n[0] <= 1'b0;
        @(posedge clk_sys);
        ev[0] <= 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        `CHK(op_mode, 2'h2)
        pin_n[3] <= 1'b0;
        wait_mode(2'h1);
        @(posedge clk_sys);
        pin_n <= 4'hf;
        for (int i = 0; i < 4; i++) rd(8'hfb + 8'(i), 8'h11 * 8'(i + 1));
    endtask
    task automatic t_restore;
        wr(8'hf1, 8'h05);
        @(posedge clk_sys);
        mains_ok <= 1'b1;
        repeat (12) @(posedge clk_sys);
        #1;
        `CHK(op_mode, 2'h1)
        rs_cnt = 0;
        wr(8'hf1, 8'h01);
        wait_mode(2'h0);
        `CHK({switched_rail, metering_analog_on, rs_cnt}, 34'h1_0000_0000)
        @(posedge clk_sys);
        mains_ok <= 1'b0;
        wait_mode(2'h1);
        go_sleep();
        @(posedge clk_sys);
        mains_ok <= 1'b1;
        wait_mode(2'h0);
        @(posedge clk_sys);
        #1;
        `CHK(rs_cnt, 1)
        rd(8'hf4, 8'h40);
    endtask
    task automatic t_delay;
        wr(8'hf1, 8'h06);
        @(posedge clk_sys);
        sense_ok <= 1'b0;
        repeat (16) @(posedge clk_sys);
        #1;
        `CHK(op_mode, 2'h0)
        wait_mode(2'h1);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        t_reset();
        t_battery();
        t_wake(0);
        t_wake(1);
        t_wake(2);
        t_wake(3);
        t_wake(4);
        t_wake(5);
        t_wake(6);
        t_wake(7);
        t_mask();
        t_restore();
        t_delay();
        conclude();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule // swm_ctrl_tb
